// file: rtl/intr_vectoring.sv
// Operation
// RULE1: Fixed order: power, console/trap, one, two, chain
// RULE2: Self-vector the four fixed lines
// RULE3: Line one to 0002, parity to 0012
// RULE4: Line two to 0006, no sharing
// RULE5: Chained winner supplies its own vector
// RULE6: Power-down vectors 001C, highest rank
// RULE7: Power return loads 0000, enters run; the code loads VEC_RESTART into vector but leaves CTRL_RUN as last written
// RULE8: Autoload starts at 0000 of ROM
// RULE9: Console in run, trap; both 001E
// RULE10: Parity on line one, below console
// RULE11: Clock 0018, sync 001A on chain
// RULE12: Serial word/end at 0002/0006, jumper 0022/0026
// RULE13: Full duplex gives four serial vectors
// RULE14: Offset jumper adds 100 to vectors
// RULE15: Restart location 0000 never offset
// RULE16: Synchronise only in main-line instruction
// RULE17: Claiming device drops downstream chain
// RULE18: Higher service drops chain priority
// RULE19: Trap>console, sync>clock, end>word, then slots
// RULE20: Power and console internal only
// RULE21: Recognise after current instruction completes
// RULE22: Address request about 2 us after acknowledge
// RULE23: Global enable gates line interrupts
// RULE24: Idle device passes chain through
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
module intr_vectoring
  import intr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Internal processor events
  input wire logic power_low_i,
  input wire logic console_switch_i,
  input wire logic trap_instruction_i,
  input wire logic parity_error_i,
  input wire logic clock_tick_i,
  input wire logic sync_tick_i,
  input wire logic ser_word_i,
  input wire logic ser_eob_i,
  input wire logic ser_word_alt_i,
  input wire logic ser_eob_alt_i,
  input wire logic instr_end_i,
  // Bus side
  intr_bus_if.cpu bus
);
  typedef enum logic [1:0] {IDLE, WAIT_REQ, ADDR_REQ, EXEC} phase_e;
  phase_e phase;
  logic [6:0] ctrl;
  logic [3:0] pend;
  logic [9:0] ev;
  logic [9:0] ev_s;
  logic [2:0] line_s;
  logic [15:0] vector;
  logic [15:0] next_vector;
  source_e source;
  source_e next_source;
  logic [7:0] cnt;
  logic restart_req;
  logic autoload_req;
  logic power_was_low;
  logic [3:0] int_pend;
  logic [5:0] ser_pend;
  logic done_req;
  logic rd_done;

  // Pins from other logic are synchronised
  pin_sync #(.W(10)) u_ev_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i({power_low_i, console_switch_i, trap_instruction_i, parity_error_i,
          clock_tick_i, sync_tick_i, ser_word_i, ser_eob_i, ser_word_alt_i, ser_eob_alt_i}),
    .q_o(ev_s)
  );
  // Bus lines come from logic on this clock and need no synchroniser
  assign line_s = {bus.fixed_line_one, bus.fixed_line_two, bus.shared_chain_request};
  assign ev = ev_s;

  // Sticky internal requests; a new event wins over its clear
  // RULE20 internal-only sources
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      int_pend <= '0;
      ser_pend <= '0;
      power_was_low <= 1'b0;
      restart_req <= 1'b0;
      autoload_req <= 1'b0;
    end else begin
      power_was_low <= ev[9];
      // RULE6 power-down request
      int_pend[3] <= (ev[9] && !power_was_low && ctrl[CTRL_RESTART_OPT])
                     || (int_pend[3] && !(phase == EXEC && source == SRC_POWER_DOWN));
      // RULE9 console in run
      int_pend[2] <= (ev[8] && ctrl[CTRL_RUN])
                     || (int_pend[2] && !(phase == EXEC && source == SRC_CONSOLE));
      int_pend[1] <= ev[7] || (int_pend[1] && !(phase == EXEC && source == SRC_TRAP));
      // RULE10 parity on line one
      int_pend[0] <= ev[6] || (int_pend[0] && !(phase == EXEC && source == SRC_PARITY));
      // RULE11 timer events
      ser_pend[5] <= ev[5] || (ser_pend[5] && !(phase == EXEC && source == SRC_CLOCK));
      ser_pend[4] <= ev[4] || (ser_pend[4] && !(phase == EXEC && source == SRC_SYNC));
      // RULE13 four serial events
      ser_pend[3] <= ev[3] || ev[1] || (ser_pend[3] && !(phase == EXEC && source == SRC_SER_WORD));
      ser_pend[2] <= ev[2] || ev[0] || (ser_pend[2] && !(phase == EXEC && source == SRC_SER_EOB));
      ser_pend[1] <= (ev[1] && ctrl[CTRL_FULL_DUPLEX])
                     || (ser_pend[1] && !(phase == EXEC && source == SRC_SER_WORD));
      ser_pend[0] <= (ev[0] && ctrl[CTRL_FULL_DUPLEX])
                     || (ser_pend[0] && !(phase == EXEC && source == SRC_SER_EOB));
      // RULE7 restart on power return
      // RULE8 autoload uses same path
      restart_req <= (!ev[9] && power_was_low && ctrl[CTRL_RESTART_OPT]) ? 1'b1
                     : (restart_req && !rd_done);
      autoload_req <= (!ev[9] && power_was_low && ctrl[CTRL_AUTOLOAD]) ? 1'b1
                      : (autoload_req && !rd_done);
    end
  end
  assign pend = {int_pend[3], int_pend[2] || int_pend[1], int_pend[0] || line_s[2], line_s[1]};

  // Priority select and vector
  always_comb begin
    next_source = SRC_NONE;
    next_vector = '0;
    // RULE1 fixed order
    // RULE19 sub-order
    // RULE23 enable gates lines
    if (int_pend[3]) begin
      next_source = SRC_POWER_DOWN;
      next_vector = VEC_POWER_DOWN;
    end else if (int_pend[1] && ctrl[CTRL_ENABLE]) begin
      next_source = SRC_TRAP;
      next_vector = VEC_CONSOLE_TRAP;
    end else if (int_pend[2] && ctrl[CTRL_ENABLE]) begin
      next_source = SRC_CONSOLE;
      next_vector = VEC_CONSOLE_TRAP;
    end else if (int_pend[0] && ctrl[CTRL_ENABLE]) begin
      // RULE3 parity forces 0012
      next_source = SRC_PARITY;
      next_vector = VEC_PARITY;
    end else if (line_s[2] && ctrl[CTRL_ENABLE]) begin
      // RULE2 self-vectored
      next_source = SRC_LINE_ONE;
      next_vector = VEC_LINE_ONE;
    end else if (line_s[1] && ctrl[CTRL_ENABLE]) begin
      // RULE4 line two
      next_source = SRC_LINE_TWO;
      next_vector = VEC_LINE_TWO;
    end else if (ser_pend[4] && ctrl[CTRL_ENABLE]) begin
      next_source = SRC_SYNC;
      next_vector = VEC_SYNC;
    end else if (ser_pend[5] && ctrl[CTRL_ENABLE]) begin
      next_source = SRC_CLOCK;
      next_vector = VEC_CLOCK;
    end else if (ser_pend[2] && ctrl[CTRL_ENABLE]) begin
      // RULE12 jumper displaces serial
      next_source = SRC_SER_EOB;
      next_vector = (ctrl[CTRL_SER_ALT] || ser_pend[0]) ? VEC_SER_EOB_ALT : VEC_SER_EOB;
    end else if (ser_pend[3] && ctrl[CTRL_ENABLE]) begin
      next_source = SRC_SER_WORD;
      next_vector = (ctrl[CTRL_SER_ALT] || ser_pend[1]) ? VEC_SER_WORD_ALT : VEC_SER_WORD;
    end else if (line_s[0] && ctrl[CTRL_ENABLE]) begin
      next_source = SRC_CHAIN;
      next_vector = '0;
    end
    // RULE14 offset jumper
    if (ctrl[CTRL_OFFSET] && next_source != SRC_CHAIN) begin
      next_vector = next_vector + VEC_OFFSET;
    end
  end

  // Interrupt sequence
  // RULE16 sync at main-line end
  // RULE21 after instruction completes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      phase <= IDLE;
      cnt <= '0;
      source <= SRC_NONE;
      vector <= '0;
      bus.interrupt_acknowledge_line <= 1'b0;
      bus.address_request_strobe <= 1'b0;
    end else begin
      unique case (phase)
        IDLE: begin
          if (instr_end_i && next_source != SRC_NONE) begin
            phase <= WAIT_REQ;
            source <= next_source;
            vector <= next_vector;
            cnt <= ACK_CNT;
            bus.interrupt_acknowledge_line <= 1'b1;
          end else if (restart_req || autoload_req) begin
            // RULE15 restart location not offset
            vector <= VEC_RESTART;
          end
        end
        WAIT_REQ: begin
          // RULE22 request after 2 us
          cnt <= cnt - 8'h01;
          if (cnt == 8'h01) begin
            phase <= ADDR_REQ;
            cnt <= REQ_CNT;
            bus.address_request_strobe <= 1'b1;
          end
        end
        ADDR_REQ: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h01) begin
            phase <= EXEC;
            bus.address_request_strobe <= 1'b0;
            if (source == SRC_CHAIN && bus.data_from_dev_oe) begin
              vector <= bus.data_from_dev;
            end
          end
        end
        EXEC: begin
          if (instr_end_i) begin
            phase <= IDLE;
            bus.interrupt_acknowledge_line <= 1'b0;
          end
        end
      endcase
    end
  end

  // RULE18 drop chain while higher served
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bus.chain_priority_in <= 1'b0;
      bus.mainline_sync <= 1'b0;
    end else begin
      bus.chain_priority_in <= !(phase != IDLE && source != SRC_CHAIN) && !(|pend);
      bus.mainline_sync <= phase == IDLE && instr_end_i && next_source == SRC_CHAIN;
    end
  end

  // Avalon slave, one wait cycle; a write lands as waitrequest is seen low
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl <= '0;
      avs_readdata_o <= '0;
      avs_waitrequest_o <= 1'b1;
      done_req <= 1'b0;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      done_req <= 1'b0;
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL) begin
        ctrl <= avs_writedata_i[6:0];
      end
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_DONE) begin
        done_req <= 1'b1;
      end
      unique case (avs_address_i)
        REG_CTRL: avs_readdata_o <= {25'h0, ctrl};
        REG_STATUS: avs_readdata_o <= {20'h0, autoload_req, restart_req, phase, source, pend};
        REG_VECTOR: avs_readdata_o <= {16'h0, vector};
        REG_DONE: avs_readdata_o <= {26'h0, ser_pend};
      endcase
    end
  end
  assign rd_done = done_req;
endmodule : intr_vectoring

// file: rtl/intr_pkg.sv
package intr_pkg;
  // Vector width and vector locations
  localparam int VEC_W = 16;
  localparam logic [15:0] VEC_RESTART = 16'h0000;
  localparam logic [15:0] VEC_LINE_ONE = 16'h0002;
  localparam logic [15:0] VEC_LINE_TWO = 16'h0006;
  localparam logic [15:0] VEC_PARITY = 16'h0012;
  localparam logic [15:0] VEC_CLOCK = 16'h0018;
  localparam logic [15:0] VEC_SYNC = 16'h001A;
  localparam logic [15:0] VEC_POWER_DOWN = 16'h001C;
  localparam logic [15:0] VEC_CONSOLE_TRAP = 16'h001E;
  localparam logic [15:0] VEC_SER_WORD = 16'h0002;
  localparam logic [15:0] VEC_SER_EOB = 16'h0006;
  localparam logic [15:0] VEC_SER_WORD_ALT = 16'h0022;
  localparam logic [15:0] VEC_SER_EOB_ALT = 16'h0026;
  localparam logic [15:0] VEC_OFFSET = 16'h0100;
  // Acknowledge to address request delay and address request length
  localparam int CLK_MHZ = 25;
  localparam int ACK_TO_REQ_NS = 2000;
  localparam int ACK_TO_REQ_CYC = (ACK_TO_REQ_NS * CLK_MHZ) / 1000;
  localparam int REQ_LEN_NS = 750;
  localparam int REQ_LEN_CYC = (REQ_LEN_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 8;
  localparam logic [7:0] ACK_CNT = 8'(ACK_TO_REQ_CYC);
  localparam logic [7:0] REQ_CNT = 8'(REQ_LEN_CYC);
  // Avalon register map (word addresses)
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_VECTOR = 2'h2;
  localparam logic [1:0] REG_DONE = 2'h3;
  // Control bit positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_OFFSET = 1;
  localparam int CTRL_SER_ALT = 2;
  localparam int CTRL_FULL_DUPLEX = 3;
  localparam int CTRL_RESTART_OPT = 4;
  localparam int CTRL_AUTOLOAD = 5;
  localparam int CTRL_RUN = 6;
  // Source kinds reported with a vector
  typedef enum logic [3:0] {
    SRC_NONE, SRC_POWER_DOWN, SRC_RESTART, SRC_AUTOLOAD, SRC_TRAP, SRC_CONSOLE,
    SRC_PARITY, SRC_LINE_ONE, SRC_LINE_TWO, SRC_SYNC, SRC_CLOCK, SRC_SER_EOB,
    SRC_SER_WORD, SRC_CHAIN
  } source_e;
endpackage : intr_pkg

// file: rtl/intr_bus_if.sv
// Shared I/O bus between processor interrupt logic and one chained peripheral
interface intr_bus_if;
  logic fixed_line_one;
  logic fixed_line_two;
  logic shared_chain_request;
  logic chain_priority_in;
  logic chain_priority_out;
  logic interrupt_acknowledge_line;
  logic address_request_strobe;
  logic [15:0] data_from_dev;
  logic data_from_dev_oe;
  logic mainline_sync;
  modport cpu (
    input fixed_line_one, fixed_line_two, shared_chain_request, chain_priority_out,
    input data_from_dev, data_from_dev_oe,
    output chain_priority_in, interrupt_acknowledge_line, address_request_strobe,
    output mainline_sync
  );
  modport dev (
    output fixed_line_one, fixed_line_two, shared_chain_request, chain_priority_out,
    output data_from_dev, data_from_dev_oe,
    input chain_priority_in, interrupt_acknowledge_line, address_request_strobe,
    input mainline_sync
  );
endinterface : intr_bus_if

// file: rtl/pin_sync.sv
// Two-stage synchroniser, one per bit
module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  // First stage feeds only the second
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : pin_sync

// file: rtl/chain_device.sv
// Peripheral end on the shared chained request line
module chain_device
  import intr_pkg::*;
#(
  parameter logic [15:0] DEV_VECTOR = 16'h0040
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // User side
  input wire logic stimulus_i,
  input wire logic dev_enable_i,
  output logic pending_o,
  output logic served_o,
  // Bus side
  intr_bus_if.dev bus
);
  logic stored;
  logic in_service;
  logic ack_d;
  logic req_d;
  logic prio_in;
  logic ack;
  logic sync_s;
  logic areq;

  // Acknowledge, strobe and priority come from logic on this clock, so no synchroniser
  assign ack = bus.interrupt_acknowledge_line;
  assign areq = bus.address_request_strobe;
  assign prio_in = bus.chain_priority_in;
  assign sync_s = bus.mainline_sync;

  // Stimulus store; a new stimulus wins over the clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stored <= 1'b0;
    end else if (stimulus_i && dev_enable_i) begin
      stored <= 1'b1;
    end else if (in_service && areq && !req_d) begin
      stored <= 1'b0;
    end
  end

  // RULE17 claim at sync
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      in_service <= 1'b0;
    end else if (!in_service && stored && prio_in && sync_s) begin
      in_service <= 1'b1;
    end else if (in_service && !ack && ack_d) begin
      in_service <= 1'b0;
    end
  end

  // Edge history
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_d <= 1'b0;
      req_d <= 1'b0;
    end else begin
      ack_d <= ack;
      req_d <= areq;
    end
  end

  // Bus outputs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bus.shared_chain_request <= 1'b0;
      bus.chain_priority_out <= 1'b0;
      bus.data_from_dev <= '0;
      bus.data_from_dev_oe <= 1'b0;
      served_o <= 1'b0;
    end else begin
      bus.shared_chain_request <= stored && prio_in && !in_service;
      // RULE24 chain passes through
      // RULE17 block downstream
      bus.chain_priority_out <= prio_in && !stored && !in_service;
      // RULE5 supply own vector
      bus.data_from_dev <= (in_service && areq) ? DEV_VECTOR : '0;
      bus.data_from_dev_oe <= in_service && areq;
      served_o <= in_service && areq && !req_d;
    end
  end
  assign bus.fixed_line_one = 1'b0;
  assign bus.fixed_line_two = 1'b0;
  assign pending_o = stored;
endmodule : chain_device

// file: tb/intr_monitor.sv
module intr_monitor (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Interface signals
  input wire logic shared_chain_request,
  input wire logic chain_priority_in,
  input wire logic chain_priority_out,
  input wire logic interrupt_acknowledge_line,
  input wire logic address_request_strobe,
  input wire logic data_from_dev_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  wire ack = interrupt_acknowledge_line;
  wire stb = address_request_strobe;
  wire oe = data_from_dev_oe;
  logic [7:0] strobe_len;
  logic strobe_q;
  logic [1:0] strobes;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // Cycles the address request has been high so far
  always_ff @(posedge sys_clk_i) begin
    strobe_q <= rst_i ? 1'b0 : stb;
    strobe_len <= (rst_i || !stb) ? 8'h00 : strobe_len + 8'h01;
  end
  // Requests per acknowledge; a second one would mean a nested interrupt
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !ack) begin
      strobes <= 2'h0;
    end else if (stb && !strobe_q && strobes != 2'h3) begin
      strobes <= strobes + 2'h1;
    end
  end
  property p_stb_in_ack; stb |-> ack; endproperty
  property p_ack_to_stb; $rose(ack) |-> ##[45:55] $rose(stb); endproperty
  property p_stb_len; $fell(stb) |-> strobe_len == 8'h12; endproperty
  a_stb_in_ack: assert property (p_stb_in_ack)
    else $error("strobe outside acknowledge");
  a_ack_to_stb: assert property (p_ack_to_stb)
    else $error("address request not about 2 us after acknowledge");
  a_stb_len: assert property (p_stb_len)
    else $error("address request length wrong");
  property p_one_stb; ack |-> strobes < 2'h2; endproperty
  a_one_stb: assert property (p_one_stb)
    else $error("second address request inside one acknowledge");
  // chained winner answers and blocks downstream
  property p_oe_in_stb; oe |-> stb || $past(stb); endproperty
  property p_oe_prio; oe |-> chain_priority_in; endproperty
  property p_oe_block; oe |-> !chain_priority_out; endproperty
  a_oe_in_stb: assert property (p_oe_in_stb)
    else $error("vector driven outside address request");
  a_oe_prio: assert property (p_oe_prio)
    else $error("vector driven without chain priority");
  a_oe_block: assert property (p_oe_block)
    else $error("downstream chain left enabled by winner");
  property p_chain_off; ack && stb && $past(stb) && !oe |-> !chain_priority_in; endproperty
  a_chain_off: assert property (p_chain_off)
    else $error("chain priority kept during higher service");
  // Main scenarios
  c_ack: cover property ($rose(ack));
  c_dev_vector: cover property (oe);
  c_internal: cover property ($fell(stb) && !shared_chain_request);
endmodule : intr_monitor

// file: tb/testbench.sv
module testbench import intr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [6:0] c;
    logic [9:0] e;
    logic s;
    logic w;
    logic [15:0] v;
  } case_s;
  // Control, events, device stimulus, recognised, vector
  localparam int N = 29;
  localparam case_s CASES [N] = '{
    '{7'h51, 10'h001, 1'b0, 1'b1, 16'h001C}, '{7'h53, 10'h001, 1'b0, 1'b1, 16'h011C},
    '{7'h51, 10'h002, 1'b0, 1'b1, 16'h001E}, '{7'h51, 10'h004, 1'b0, 1'b1, 16'h001E},
    '{7'h51, 10'h008, 1'b0, 1'b1, 16'h0012}, '{7'h51, 10'h010, 1'b0, 1'b1, 16'h0018},
    '{7'h51, 10'h020, 1'b0, 1'b1, 16'h001A}, '{7'h51, 10'h040, 1'b0, 1'b1, 16'h0002},
    '{7'h51, 10'h080, 1'b0, 1'b1, 16'h0006}, '{7'h55, 10'h040, 1'b0, 1'b1, 16'h0022},
    '{7'h55, 10'h080, 1'b0, 1'b1, 16'h0026}, '{7'h59, 10'h100, 1'b0, 1'b1, 16'h0022},
    '{7'h59, 10'h200, 1'b0, 1'b1, 16'h0026}, '{7'h53, 10'h002, 1'b0, 1'b1, 16'h011E},
    '{7'h53, 10'h010, 1'b0, 1'b1, 16'h0118}, '{7'h53, 10'h008, 1'b0, 1'b1, 16'h0112},
    '{7'h53, 10'h000, 1'b1, 1'b1, 16'h0040}, '{7'h51, 10'h00F, 1'b0, 1'b1, 16'h001C},
    '{7'h51, 10'h00E, 1'b0, 1'b1, 16'h001E}, '{7'h51, 10'h038, 1'b0, 1'b1, 16'h0012},
    '{7'h51, 10'h030, 1'b0, 1'b1, 16'h001A}, '{7'h51, 10'h0D0, 1'b0, 1'b1, 16'h0018},
    '{7'h51, 10'h0C0, 1'b0, 1'b1, 16'h0006}, '{7'h51, 10'h040, 1'b1, 1'b1, 16'h0002},
    '{7'h50, 10'h000, 1'b1, 1'b0, 16'h0000}, '{7'h51, 10'h000, 1'b0, 1'b1, 16'h0040},
    '{7'h50, 10'h001, 1'b0, 1'b1, 16'h001C}, '{7'h11, 10'h002, 1'b0, 1'b0, 16'h0000},
    '{7'h51, 10'h008, 1'b0, 1'b1, 16'h0012}
  };
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] avs_address_i = 2'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [9:0] ev = 10'h000;
  logic instr_end_i = 1'b0;
  logic stim = 1'b0;
  logic [31:0] rd;
  int miscompares = 0;
  int check_count = 0;
  intr_bus_if link ();
  // Design ends and checker
  intr_vectoring i_intr_vectoring (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .power_low_i(ev[0]), .console_switch_i(ev[1]), .trap_instruction_i(ev[2]),
    .parity_error_i(ev[3]), .clock_tick_i(ev[4]), .sync_tick_i(ev[5]), .ser_word_i(ev[6]),
    .ser_eob_i(ev[7]), .ser_word_alt_i(ev[8]), .ser_eob_alt_i(ev[9]), .instr_end_i,
    .bus(link));
  chain_device i_chain_device (.sys_clk_i, .rst_i, .stimulus_i(stim), .dev_enable_i(1'b1),
    .pending_o(), .served_o(), .bus(link));
  intr_monitor i_intr_monitor (.sys_clk_i, .rst_i,
    .shared_chain_request(link.shared_chain_request),
    .chain_priority_in(link.chain_priority_in), .chain_priority_out(link.chain_priority_out),
    .interrupt_acknowledge_line(link.interrupt_acknowledge_line),
    .address_request_strobe(link.address_request_strobe),
    .data_from_dev_oe(link.data_from_dev_oe));
  // 25 MHz clock
  always #20 sys_clk_i = ~sys_clk_i;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // A wait that runs out counts as a mismatch and ends the run
  task automatic hang(input string what);
    check(what, 32'h0, 32'h1);
    give_verdict();
  endtask : hang
  // Avalon access held until waitrequest is sampled low
  task automatic access(input logic [1:0] a, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= wd;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) hang("waitrequest");
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : access
  // End of one main-line instruction
  task automatic step();
    instr_end_i <= 1'b1;
    @(posedge sys_clk_i);
    instr_end_i <= 1'b0;
  endtask : step
  task automatic serve(input logic want, input logic [15:0] exp, input bit chk);
    int n;
    repeat (10) @(posedge sys_clk_i);
    step();
    n = 0;
    while (link.interrupt_acknowledge_line !== 1'b1 && n < 8) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (chk) check("recognised", {31'h0, link.interrupt_acknowledge_line}, {31'h0, want});
    // Events are dropped even when refused, so they cannot leak into the next case
    ev <= 10'h000;
    if (link.interrupt_acknowledge_line === 1'b1) begin
      n = 0;
      while (link.address_request_strobe !== 1'b1 && n < 200) begin
        @(posedge sys_clk_i);
        n++;
      end
      while (link.address_request_strobe !== 1'b0 && n < 200) begin
        @(posedge sys_clk_i);
        n++;
      end
      if (n >= 200) hang("address request");
      access(REG_VECTOR, 1'b0, 32'h0);
      if (chk) check("vector", {16'h0, rd[15:0]}, {16'h0, exp});
      step();
      n = 0;
      while (link.interrupt_acknowledge_line !== 1'b0 && n < 8) begin
        @(posedge sys_clk_i);
        n++;
      end
      if (n >= 8) hang("acknowledge release");
    end
  endtask : serve
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    access(REG_CTRL, 1'b1, 32'h51);
    access(REG_CTRL, 1'b0, 32'h0);
    check("control", rd & 32'h7F, 32'h51);
    for (int i = 0; i < N; i++) begin
      access(REG_CTRL, 1'b1, {25'h0, CASES[i].c});
      ev <= CASES[i].e;
      stim <= CASES[i].s;
      @(posedge sys_clk_i);
      stim <= 1'b0;
      serve(CASES[i].w, CASES[i].v, 1'b1);
      // Leftover lower requests are served unchecked
      repeat (3) serve(1'b0, 16'h0, 1'b0);
      access(REG_DONE, 1'b1, 32'h0);
      $display("test %0d done", i);
    end
    // No serial request may stay pending once all were served
    access(REG_DONE, 1'b0, 32'h0);
    check("serial pending", rd, 32'h0);
    // Power return with restart and autoload, offset on
    access(REG_CTRL, 1'b1, 32'h73);
    ev <= 10'h001;
    @(posedge sys_clk_i);
    serve(1'b1, 16'h011C, 1'b1);
    repeat (6) @(posedge sys_clk_i);
    access(REG_STATUS, 1'b0, 32'h0);
    check("restart", {30'h0, rd[11:10]}, 32'h3);
    access(REG_VECTOR, 1'b0, 32'h0);
    check("restart vector", rd, 32'h0);
    access(REG_DONE, 1'b1, 32'h0);
    access(REG_STATUS, 1'b0, 32'h0);
    check("restart cleared", {30'h0, rd[11:10]}, 32'h0);
    $display("test restart done");
    give_verdict();
  end
endmodule : testbench
